//--- shared/bdio_regs.svh
// Purpose: Offsets, field positions, reset values and masks for the digital I/O block.
// Assumes: Host I/O addresses are twelve bits wide.
// Notes:   Definitions only; included by bare name.
`ifndef BDIO_REGS_SVH
`define BDIO_REGS_SVH

`define BDIO_ADDR_W          12
`define BDIO_ADDR_BOUT       12'h100
`define BDIO_ADDR_BIN        12'h101
`define BDIO_ADDR_TA_DATA    12'h080
`define BDIO_ADDR_TA_DIR     12'h081
`define BDIO_ADDR_TB_DATA    12'h082
`define BDIO_ADDR_TB_DIR     12'h083
`define BDIO_ADDR_TC_DATA    12'h08c
`define BDIO_ADDR_TC_DIR     12'h08d

`define BDIO_BOUT_RESET      8'h00
`define BDIO_TTL_DATA_RESET  8'h00
`define BDIO_TTL_DIR_RESET   8'h00
`define BDIO_UNMAPPED_READ   8'h00

`define BDIO_FULL_MASK       8'hff
`define BDIO_TC_LINE_MASK    8'h9c

`define BDIO_TC_THIRD_RTS_BIT  3
`define BDIO_TC_SECOND_RTS_BIT 4
`define BDIO_TC_BACKLT_BIT   7

`endif

//--- shared/bdio_pkg.sv
// Purpose: Types shared by the digital I/O block.
// Assumes: Offsets live in bdio_regs.svh.
// Notes:   Register selects decoded from a host I/O address.
`default_nettype none

package bdio_pkg;

    typedef enum {
        BDIO_SEL_NONE,
        BDIO_SEL_BOUT,
        BDIO_SEL_BIN,
        BDIO_SEL_TA_DATA,
        BDIO_SEL_TA_DIR,
        BDIO_SEL_TB_DATA,
        BDIO_SEL_TB_DIR,
        BDIO_SEL_TC_DATA,
        BDIO_SEL_TC_DIR
    } bdio_sel_t;

endpackage

`default_nettype wire

//--- design/bdio_ttl_port.sv
// Purpose: One eight-bit programmable TTL port with a data and a direction register.
// Assumes: Direction bit one means the line is an output.
// Notes:   Lines outside the mask are never driven and read as zero.
`include "bdio_regs.svh"
`default_nettype none

module bdio_ttl_port #(
    parameter logic [7:0] LINE_MASK = `BDIO_FULL_MASK
) (
    input  wire logic       clk,        // System clock.
    input  wire logic       rst_n,      // Synchronous reset, active low.
    input  wire logic       wr_data,    // Write strobe for the data register.
    input  wire logic       wr_dir,     // Write strobe for the direction register.
    input  wire logic [7:0] wdata,      // Host write data.
    input  wire logic [7:0] pin_in,     // Level seen on the lines.
    output logic      [7:0] pin_out,    // Level driven on output lines.
    output logic      [7:0] pin_oe,     // High where the line is driven.
    output logic      [7:0] level       // Driven level or external level per line.
);

    // Data register; it keeps its value while a line is an input.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pin_out <= `BDIO_TTL_DATA_RESET;
        else if (wr_data)
            pin_out <= wdata & LINE_MASK;
    end

    // Direction register; lines start as inputs so nothing fights a field device.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pin_oe <= `BDIO_TTL_DIR_RESET;
        else if (wr_dir)
            pin_oe <= wdata & LINE_MASK;
    end

    // An output line reports what it drives, an input line what it sees.
    assign level = ((pin_oe & pin_out) | (~pin_oe & pin_in)) & LINE_MASK;

endmodule

`default_nettype wire

//--- design/bdio_top.sv
// Purpose: Buffered and TTL digital I/O reached through host I/O reads and writes.
// Assumes: Host strobes and pins are synchronous to clk; one access per strobe cycle.
// Notes:   Read data appear one cycle after the read strobe, with a valid pulse.
//
// How it works
// - Each of eight buffered outputs switches on or off independently.
// - After reset all buffered outputs are off.
// - Buffered output levels come from the port at address 100H.
// - A one turns the driver on and grounds the pin; zero releases it.
// - Reading an output port returns the levels currently driven.
// - Buffered input at 101H reads zero when grounded, one when open.
// - Buffered inputs are read-only; buffered outputs can be read back and rewritten.
// - Buffered input changes raise no interrupt; software polls.
// - Twenty TTL lines, each individually an input or an output.
// - TTL lines sit at 80h, 82h and 8Ch.
// - Control bits 3, 4, 7 feed third RTS, second RTS, backlight.
// - An input control bit passes its external level to its function.
// - Control bit 7 high lights the backlight; low turns it off.
`include "bdio_regs.svh"
`default_nettype none

module bdio_top (
    input  wire logic                    clk,                  // 10 MHz clock.
    input  wire logic                    rst_n,                // Sync reset, active low.
    input  wire logic [`BDIO_ADDR_W-1:0] io_addr,              // Host I/O address.
    input  wire logic                    io_wr,                // Host write strobe.
    input  wire logic                    io_rd,                // Host read strobe.
    input  wire logic [7:0]              io_wdata,             // Host write data.
    output logic      [7:0]              io_rdata,             // Host read data.
    output logic                         io_rvalid,            // Read data valid pulse.
    output logic      [7:0]              buffered_out_lines,   // High turns driver on.
    input  wire logic [7:0]              buffered_in_lines,    // Low when input grounded.
    input  wire logic [7:0]              ttl_first_port_in,    // First port line levels.
    output logic      [7:0]              ttl_first_port_out,   // First port drive levels.
    output logic      [7:0]              ttl_first_port_oe,    // First port drive enables.
    input  wire logic [7:0]              ttl_second_port_in,   // Second port line levels.
    output logic      [7:0]              ttl_second_port_out,  // Second port drive levels.
    output logic      [7:0]              ttl_second_port_oe,   // Second port drive enables.
    input  wire logic [7:0]              ttl_control_port_in,  // Control port line levels.
    output logic      [7:0]              ttl_control_port_out, // Control port drive levels.
    output logic      [7:0]              ttl_control_port_oe,  // Control port drive enables.
    output logic                         third_serial_rts,     // Third channel RTS level.
    output logic                         second_serial_rts,    // Second channel RTS level.
    output logic                         lcd_backlight         // High lights the backlight.
);

    // Address decode shared by the write and the read paths.
    function automatic bdio_pkg::bdio_sel_t decode(input logic [`BDIO_ADDR_W-1:0] a);
        unique case (a)
            `BDIO_ADDR_BOUT:    decode = bdio_pkg::BDIO_SEL_BOUT;
            `BDIO_ADDR_BIN:     decode = bdio_pkg::BDIO_SEL_BIN;
            `BDIO_ADDR_TA_DATA: decode = bdio_pkg::BDIO_SEL_TA_DATA;
            `BDIO_ADDR_TA_DIR:  decode = bdio_pkg::BDIO_SEL_TA_DIR;
            `BDIO_ADDR_TB_DATA: decode = bdio_pkg::BDIO_SEL_TB_DATA;
            `BDIO_ADDR_TB_DIR:  decode = bdio_pkg::BDIO_SEL_TB_DIR;
            `BDIO_ADDR_TC_DATA: decode = bdio_pkg::BDIO_SEL_TC_DATA;
            `BDIO_ADDR_TC_DIR:  decode = bdio_pkg::BDIO_SEL_TC_DIR;
            default:            decode = bdio_pkg::BDIO_SEL_NONE;
        endcase
    endfunction

    bdio_pkg::bdio_sel_t sel;
    logic [7:0]          ta_level;
    logic [7:0]          tb_level;
    logic [7:0]          tc_level;
    logic [7:0]          rd_mux;

    assign sel = decode(io_addr);

    // Buffered output register; a one switches the sinking driver on.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            buffered_out_lines <= `BDIO_BOUT_RESET;
        else if (io_wr && sel == bdio_pkg::BDIO_SEL_BOUT)
            buffered_out_lines <= io_wdata;
    end

    // The three TTL ports; only four control port bits reach the header.
    bdio_ttl_port #(.LINE_MASK(`BDIO_FULL_MASK)) u_first (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_data (io_wr && sel == bdio_pkg::BDIO_SEL_TA_DATA),
        .wr_dir  (io_wr && sel == bdio_pkg::BDIO_SEL_TA_DIR),
        .wdata   (io_wdata),
        .pin_in  (ttl_first_port_in),
        .pin_out (ttl_first_port_out),
        .pin_oe  (ttl_first_port_oe),
        .level   (ta_level)
    );

    bdio_ttl_port #(.LINE_MASK(`BDIO_FULL_MASK)) u_second (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_data (io_wr && sel == bdio_pkg::BDIO_SEL_TB_DATA),
        .wr_dir  (io_wr && sel == bdio_pkg::BDIO_SEL_TB_DIR),
        .wdata   (io_wdata),
        .pin_in  (ttl_second_port_in),
        .pin_out (ttl_second_port_out),
        .pin_oe  (ttl_second_port_oe),
        .level   (tb_level)
    );

    bdio_ttl_port #(.LINE_MASK(`BDIO_TC_LINE_MASK)) u_control (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_data (io_wr && sel == bdio_pkg::BDIO_SEL_TC_DATA),
        .wr_dir  (io_wr && sel == bdio_pkg::BDIO_SEL_TC_DIR),
        .wdata   (io_wdata),
        .pin_in  (ttl_control_port_in),
        .pin_out (ttl_control_port_out),
        .pin_oe  (ttl_control_port_oe),
        .level   (tc_level)
    );

    // Read selection; the buffered input has no write path and no interrupt.
    always_comb
    begin
        unique case (sel)
            bdio_pkg::BDIO_SEL_BOUT:    rd_mux = buffered_out_lines;
            bdio_pkg::BDIO_SEL_BIN:     rd_mux = buffered_in_lines;
            bdio_pkg::BDIO_SEL_TA_DATA: rd_mux = ta_level;
            bdio_pkg::BDIO_SEL_TA_DIR:  rd_mux = ttl_first_port_oe;
            bdio_pkg::BDIO_SEL_TB_DATA: rd_mux = tb_level;
            bdio_pkg::BDIO_SEL_TB_DIR:  rd_mux = ttl_second_port_oe;
            bdio_pkg::BDIO_SEL_TC_DATA: rd_mux = tc_level;
            bdio_pkg::BDIO_SEL_TC_DIR:  rd_mux = ttl_control_port_oe;
            bdio_pkg::BDIO_SEL_NONE:    rd_mux = `BDIO_UNMAPPED_READ;
        endcase
    end

    // Read data are registered and held, so the host sees a stable byte until the next read strobe.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            io_rdata <= `BDIO_UNMAPPED_READ;
        else if (io_rd)
            io_rdata <= rd_mux;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            io_rvalid <= 1'b0;
        else
            io_rvalid <= io_rd;
    end

    // Shared functions follow the line level, so an input bit passes the external drive.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            third_serial_rts  <= 1'b0;
            second_serial_rts <= 1'b0;
            lcd_backlight     <= 1'b0;
        end
        else
        begin
            third_serial_rts  <= tc_level[`BDIO_TC_THIRD_RTS_BIT];
            second_serial_rts <= tc_level[`BDIO_TC_SECOND_RTS_BIT];
            lcd_backlight     <= tc_level[`BDIO_TC_BACKLT_BIT];
        end
    end

    // Checks on the behaviour above.
    sequence s_bout_write;
        io_wr && sel == bdio_pkg::BDIO_SEL_BOUT;
    endsequence

    sequence s_bout_read;
        io_rd && !io_wr && sel == bdio_pkg::BDIO_SEL_BOUT;
    endsequence

    property p_bout_reset_off;
        @(posedge clk) $rose(rst_n) |-> buffered_out_lines == 8'h00;
    endproperty
    a_bout_reset_off: assert property (p_bout_reset_off)
        else $error("Buffered outputs not off after reset.");

    property p_bout_write;
        @(posedge clk) disable iff (!rst_n)
        s_bout_write |=> buffered_out_lines == $past(io_wdata);
    endproperty
    a_bout_write: assert property (p_bout_write)
        else $error("Buffered output write not applied.");

    property p_bout_hold;
        @(posedge clk) disable iff (!rst_n)
        !(io_wr && sel == bdio_pkg::BDIO_SEL_BOUT) |=> $stable(buffered_out_lines);
    endproperty
    a_bout_hold: assert property (p_bout_hold)
        else $error("Buffered outputs changed without a write.");

    property p_bout_readback;
        @(posedge clk) disable iff (!rst_n)
        s_bout_write ##1 s_bout_read |=> io_rdata == $past(io_wdata, 2) && io_rvalid;
    endproperty
    a_bout_readback: assert property (p_bout_readback)
        else $error("Buffered output read-back mismatch.");

    property p_bin_read;
        @(posedge clk) disable iff (!rst_n)
        io_rd && sel == bdio_pkg::BDIO_SEL_BIN |=> io_rdata == $past(buffered_in_lines);
    endproperty
    a_bin_read: assert property (p_bin_read)
        else $error("Buffered input read does not show the pins.");

    property p_bin_no_write;
        @(posedge clk) disable iff (!rst_n)
        io_wr && sel == bdio_pkg::BDIO_SEL_BIN |=> $stable(buffered_out_lines);
    endproperty
    a_bin_no_write: assert property (p_bin_no_write)
        else $error("Write to the input port disturbed outputs.");

    property p_first_dir;
        @(posedge clk) disable iff (!rst_n)
        io_wr && sel == bdio_pkg::BDIO_SEL_TA_DIR |=> ttl_first_port_oe == $past(io_wdata);
    endproperty
    a_first_dir: assert property (p_first_dir)
        else $error("First port direction not applied.");

    property p_control_mask;
        @(posedge clk) disable iff (!rst_n)
        (ttl_control_port_oe & ~`BDIO_TC_LINE_MASK) == 8'h00;
    endproperty
    a_control_mask: assert property (p_control_mask)
        else $error("Control port drives a line that is not on the header.");

    property p_rts_follow;
        @(posedge clk) disable iff (!rst_n)
        !ttl_control_port_oe[3] ##1 !ttl_control_port_oe[3]
            |-> third_serial_rts == $past(ttl_control_port_in[3]);
    endproperty
    a_rts_follow: assert property (p_rts_follow)
        else $error("Third RTS does not follow its external level.");

    property p_rts_driven;
        @(posedge clk) disable iff (!rst_n)
        ttl_control_port_oe[4] |=> second_serial_rts == $past(ttl_control_port_out[4]);
    endproperty
    a_rts_driven: assert property (p_rts_driven)
        else $error("Second RTS does not follow its driven level.");

    property p_backlight;
        @(posedge clk) disable iff (!rst_n)
        ttl_control_port_oe[7] && ttl_control_port_out[7] |=> lcd_backlight;
    endproperty
    a_backlight: assert property (p_backlight)
        else $error("Backlight off while bit 7 driven high.");

endmodule

`default_nettype wire

//--- testbench/bdio_field_model.sv
// Purpose: Field devices on the pins: contacts on the inputs, TTL devices on the lines.
// Assumes: An undriven TTL line shows the level the device puts on it.
// Notes:   Combinational; the bench sets contact states and device levels.
`default_nettype none

module bdio_field_model (
    input  wire logic [7:0] sw_closed, // One where a contact grounds an input.
    input  wire logic [7:0] ext_a,     // Device level, first port.
    input  wire logic [7:0] ext_b,     // Device level, second port.
    input  wire logic [7:0] ext_c,     // Device level, control port.
    input  wire logic [7:0] out_a,     // Block drive, first port.
    input  wire logic [7:0] out_b,     // Block drive, second port.
    input  wire logic [7:0] out_c,     // Block drive, control port.
    input  wire logic [7:0] oe_a,      // Block enable, first port.
    input  wire logic [7:0] oe_b,      // Block enable, second port.
    input  wire logic [7:0] oe_c,      // Block enable, control port.
    output logic      [7:0] bin,       // Buffered input levels.
    output logic      [7:0] line_a,    // First port line levels.
    output logic      [7:0] line_b,    // Second port line levels.
    output logic      [7:0] line_c     // Control port line levels.
);
    timeunit 1ns;
    timeprecision 1ns;

    // A closed contact lights the coupler and grounds the input; open pulls it up.
    assign bin = ~sw_closed;
    // Where the block drives, the device only listens, so there is no contention.
    assign line_a = (oe_a & out_a) | (~oe_a & ext_a);
    assign line_b = (oe_b & out_b) | (~oe_b & ext_b);
    assign line_c = (oe_c & out_c) | (~oe_c & ext_c);
endmodule

`default_nettype wire

//--- testbench/buffered_and_ttl_digital_io_test.sv
// Purpose: Self-checking bench for the buffered and TTL digital I/O block.
// Assumes: Inputs change on the falling edge; read data come one cycle late.
// Notes:   Every wait is bounded; a stuck read ends the run.
`include "bdio_regs.svh"
`default_nettype none

module buffered_and_ttl_digital_io_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic                    clk;
    logic                    rst_n;
    logic [`BDIO_ADDR_W-1:0] io_addr;
    logic                    io_wr;
    logic                    io_rd;
    logic [7:0]              io_wdata;
    logic [7:0]              io_rdata;
    logic                    io_rvalid;
    logic [7:0]              bout;
    logic [7:0]              bin;
    logic [7:0]              sw_closed;
    logic [7:0]              ext [3];
    wire logic [7:0]         lin [3];
    wire logic [7:0]         pout [3];
    wire logic [7:0]         poe [3];
    logic                    rts3;
    logic                    rts2;
    logic                    blight;
    int                      err_count;
    int                      n_tests;

    bdio_top uut (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .buffered_out_lines(bout), .buffered_in_lines(bin),
        .ttl_first_port_in(lin[0]), .ttl_first_port_out(pout[0]), .ttl_first_port_oe(poe[0]),
        .ttl_second_port_in(lin[1]), .ttl_second_port_out(pout[1]), .ttl_second_port_oe(poe[1]),
        .ttl_control_port_in(lin[2]), .ttl_control_port_out(pout[2]),
        .ttl_control_port_oe(poe[2]), .third_serial_rts(rts3), .second_serial_rts(rts2),
        .lcd_backlight(blight));

    bdio_field_model u_field (.sw_closed(sw_closed), .ext_a(ext[0]), .ext_b(ext[1]),
        .ext_c(ext[2]), .out_a(pout[0]), .out_b(pout[1]), .out_c(pout[2]), .oe_a(poe[0]),
        .oe_b(poe[1]), .oe_c(poe[2]), .bin(bin), .line_a(lin[0]), .line_b(lin[1]),
        .line_c(lin[2]));

    // Half-period toggle gives 100 ns.
    always #50 clk = ~clk;

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic io_write(input logic [`BDIO_ADDR_W-1:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask

    // The valid pulse is awaited for a few cycles only, so a dead bus cannot hang us.
    task automatic io_read(input logic [`BDIO_ADDR_W-1:0] a, output logic [7:0] d);
        int n;
        @(negedge clk);
        io_addr = a;
        io_rd   = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        n = 0;
        while (io_rvalid !== 1'b1 && n < 4)
        begin
            @(negedge clk);
            n++;
        end
        if (io_rvalid !== 1'b1)
        begin
            chk1(io_rvalid, 1'b1);
            report_and_stop();
        end
        d = io_rdata;
    endtask

    task automatic rd_chk(input logic [`BDIO_ADDR_W-1:0] a, input logic [7:0] exp);
        logic [7:0] r;
        io_read(a, r);
        chk8(r, exp);
    endtask

    task automatic t_reset();
        chk8(bout, 8'h00);
        chk8(poe[0] | poe[1] | poe[2], 8'h00);
        rd_chk(`BDIO_ADDR_BOUT, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_bout();
        logic [7:0] r;
        for (int i = 0; i < 8; i++)
        begin
            io_write(`BDIO_ADDR_BOUT, 8'h01 << i);
            chk8(bout, 8'h01 << i);
            rd_chk(`BDIO_ADDR_BOUT, 8'h01 << i);
        end
        io_write(`BDIO_ADDR_BOUT, 8'ha5);
        io_read(`BDIO_ADDR_BOUT, r);
        io_write(`BDIO_ADDR_BOUT, r | 8'h02);
        chk8(bout, 8'ha7);
        // Write then read on the very next edge; the read must see the fresh byte.
        @(negedge clk);
        io_addr  = `BDIO_ADDR_BOUT;
        io_wdata = 8'h3c;
        io_wr    = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        chk8(io_rdata, 8'h3c);
        chk1(io_rvalid, 1'b1);
        @(negedge clk);
        chk1(io_rvalid, 1'b0);
        chk8(io_rdata, 8'h3c);
        io_write(`BDIO_ADDR_BOUT, 8'h00);
        chk8(bout, 8'h00);
        $display("test buffered outputs done");
    endtask

    task automatic t_bin();
        sw_closed = 8'h81;
        rd_chk(`BDIO_ADDR_BIN, 8'h7e);
        io_write(`BDIO_ADDR_BIN, 8'hff);
        sw_closed = 8'h3c;
        rd_chk(`BDIO_ADDR_BIN, 8'hc3);
        chk8(bout, 8'h00);
        rd_chk(12'h0ff, 8'h00);
        $display("test buffered inputs done");
    endtask

    // Half the lines drive, half listen, so each data read mixes both sources.
    task automatic t_ttl();
        logic [`BDIO_ADDR_W-1:0] da [3] = '{12'h080, 12'h082, 12'h08c};
        logic [`BDIO_ADDR_W-1:0] dr [3] = '{12'h081, 12'h083, 12'h08d};
        logic [7:0]              mk [3] = '{8'hff, 8'hff, 8'h9c};
        for (int i = 0; i < 3; i++)
        begin
            ext[i] = 8'h5a;
            io_write(dr[i], 8'h0f);
            io_write(da[i], 8'h33);
            chk8(poe[i], 8'h0f & mk[i]);
            chk8(pout[i] & poe[i], 8'h03 & mk[i]);
            rd_chk(da[i], 8'h53 & mk[i]);
            rd_chk(dr[i], 8'h0f & mk[i]);
            io_write(dr[i], 8'h00);
        end
        $display("test ttl ports done");
    endtask

    task automatic t_ctrl();
        io_write(`BDIO_ADDR_TC_DIR, 8'h98);
        io_write(`BDIO_ADDR_TC_DATA, 8'h88);
        @(negedge clk);
        chk8({rts3, rts2, blight}, 8'h05);
        io_write(`BDIO_ADDR_TC_DATA, 8'h10);
        @(negedge clk);
        chk8({rts3, rts2, blight}, 8'h02);
        ext[2] = 8'h88;
        io_write(`BDIO_ADDR_TC_DIR, 8'h00);
        @(negedge clk);
        chk8(poe[2], 8'h00);
        chk8({rts3, rts2, blight}, 8'h05);
        ext[2] = 8'h10;
        @(negedge clk);
        chk1(blight, 1'b0);
        chk1(rts2, 1'b1);
        $display("test control functions done");
    endtask

    // A reset in mid-run must drop every driver, whatever was written before it.
    task automatic t_rerst();
        io_write(`BDIO_ADDR_BOUT, 8'hff);
        io_write(`BDIO_ADDR_TA_DIR, 8'hff);
        io_write(`BDIO_ADDR_TA_DATA, 8'ha5);
        chk8(bout & pout[0], 8'ha5);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        chk8(bout, 8'h00);
        chk8(poe[0] | pout[0], 8'h00);
        rd_chk(`BDIO_ADDR_BOUT, 8'h00);
        $display("test mid-run reset done");
    endtask

    initial
    begin
        clk       = 1'b0;
        rst_n     = 1'b0;
        io_addr   = 12'h000;
        io_wr     = 1'b0;
        io_rd     = 1'b0;
        io_wdata  = 8'h00;
        sw_closed = 8'h00;
        ext       = '{8'h00, 8'h00, 8'h00};
        err_count = 0;
        n_tests   = 0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_bout();
        t_bin();
        t_ttl();
        t_ctrl();
        t_rerst();
        report_and_stop();
    end
endmodule

`default_nettype wire
